// ==== design/bstap_host.sv ====
// tester-side tap sequencer: drives test clock, mode select and data
//
// Contract
// - from idle, two highs reach select-ir, then a low enters capture-ir.
// - shift-ir lasts six cycles to load a whole instruction.
// - ir pause goes via exit1 to pause, resume via exit2 to shift.
// - high in shift-ir moves to exit1-ir and ends shifting.
// - from update, high goes to select-dr, low to idle.
// - from idle one high reaches select-dr; last instruction picks register.
// - shift-dr keeps mode select low for register length cycles.
// - dr pause via exit1/pause, resume via exit2; high ends at exit1-dr.
// - reset by reset pin low or five or more highs on mode select.
// - tester resets the port before its first access.
// - after reset a low enters idle; held low to stay idle.
`timescale 1ns/1ps
module bstap_host
  import bstap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // command: kind 0 = instruction scan, 1 = data scan, 2 = test reset (walks reset only if tap is in reset; from idle an empty ir scan)
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [1:0] cmd_kind_i,
  input wire logic [8:0] cmd_len_i,
  input wire logic [5:0] cmd_ir_i,
  input wire logic [FIFO_WIDTH-1:0] cmd_tdi_i,
  input wire logic cmd_pause_i,
  // captured bits, 16 per word, first shifted bit in bit 0
  output logic rx_valid_o,
  input wire logic rx_ready_i,
  output logic [FIFO_WIDTH-1:0] rx_data_o,
  output logic busy_o,
  output logic test_clock_pin_o,
  output logic test_mode_select_pin_o,
  output logic test_data_in_pin_o,
  output logic test_reset_n_pin_o,
  input wire logic test_data_out_pin_i
);
  bstap_seq_type seq;
  bstap_state_type tap;
  bstap_state_type next_tap;
  logic [3:0] div;
  logic tck;
  logic tms;
  logic tdi;
  logic trst_n;
  logic [1:0] kind;
  logic [8:0] len;
  logic [8:0] bitn;
  logic [5:0] ir;
  logic [FIFO_WIDTH-1:0] tdi_word;
  logic pause_req;
  logic paused;
  logic [2:0] hi_cnt;
  logic [2:0] tdo_sync;
  logic tdo_bit;
  logic [FIFO_WIDTH-1:0] rx_sh;
  logic [4:0] rx_n;
  logic rx_push;
  logic rx_ready;
  logic [FIFO_WIDTH-1:0] rx_word;
  logic shifting;
  logic last_bit;
  logic rise;
  logic fall;
  assign fall = (seq == SEQ_HI) && (div == TCK_HALF - 4'h1);
  assign rise = (seq == SEQ_LO) && (div == TCK_HALF - 4'h1);
  assign shifting = (tap == TAP_SH_DR) || (tap == TAP_SH_IR);
  assign last_bit = bitn == len - 9'h001;
  assign cmd_ready_o = seq == SEQ_IDLE;
  assign busy_o = seq != SEQ_IDLE;
  assign test_clock_pin_o = tck;
  assign test_mode_select_pin_o = tms;
  assign test_data_in_pin_o = tdi;
  assign test_reset_n_pin_o = trst_n;
  // tracking copy of the device sixteen-state table
  always_comb begin
    unique case (tap)
      TAP_RESET: next_tap = tms ? TAP_RESET : TAP_IDLE;
      TAP_IDLE: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_tap = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: next_tap = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_tap = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_tap = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_tap = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_tap = tms ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: next_tap = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_tap = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_tap = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_tap = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_tap = tms ? TAP_SEL_DR : TAP_IDLE;
      default: next_tap = TAP_RESET;
    endcase
  end
  // device advances on rising edge, so mirror it there
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tap <= TAP_RESET;
    end else if (rise) begin
      tap <= next_tap;
    end
  end
  // clock divider: test clock made here, no second domain
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 4'h0;
      tck <= 1'b0;
    end else if (seq == SEQ_HI || seq == SEQ_LO) begin
      div <= (div == TCK_HALF - 4'h1) ? 4'h0 : div + 4'h1;
      if (div == TCK_HALF - 4'h1) begin
        tck <= ~tck;
      end
    end else begin
      div <= 4'h0;
      tck <= 1'b0;
    end
  end
  // sequencer walks tck phases: LO (ends in rise), HI (ends in fall)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq <= SEQ_IDLE;
    end else begin
      unique case (seq)
        SEQ_IDLE: if (cmd_valid_i) seq <= SEQ_LOAD;
        SEQ_LOAD: seq <= SEQ_LO;
        SEQ_LO: if (rise) seq <= SEQ_HI;
        SEQ_HI: if (fall) seq <= (tap == TAP_IDLE && hi_cnt == 3'h7)
          ? SEQ_DONE : SEQ_LO;
        SEQ_DONE: seq <= SEQ_IDLE;
        default: seq <= SEQ_IDLE;
      endcase
    end
  end
  // command latch
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind <= 2'h0;
      len <= 9'h000;
      ir <= IR_IDCODE;
      pause_req <= 1'b0;
    end else if (seq == SEQ_IDLE && cmd_valid_i) begin
      kind <= cmd_kind_i;
      len <= (cmd_kind_i == 2'h0) ? 9'(IR_LEN) : cmd_len_i;
      ir <= cmd_ir_i;
      pause_req <= cmd_pause_i;
    end
  end
  // drive mode select after each falling edge, for next rising edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tms <= 1'b1;
      hi_cnt <= 3'h0;
      bitn <= 9'h000;
      paused <= 1'b0;
      trst_n <= 1'b0;
      tdi <= 1'b0;
    end else if (seq == SEQ_LOAD) begin
      hi_cnt <= 3'h0;
      bitn <= 9'h000;
      paused <= 1'b0;
      trst_n <= 1'b1;
      // test reset or tap in reset: mode select starts high; pin released
      tms <= kind == 2'h2 || tap == TAP_RESET;
      tdi <= 1'b0;
    end else if (rise) begin
      // a reset walk counts five highs before leaving reset
      if (tap == TAP_RESET && hi_cnt < 3'(RESET_TMS_CYC)) begin
        hi_cnt <= hi_cnt + 3'h1;
      end
      if (shifting) begin
        bitn <= bitn + 9'h001;
      end
    end else if (fall) begin
      unique case (tap)
        TAP_RESET: begin
          tms <= hi_cnt < 3'(RESET_TMS_CYC);
        end
        TAP_IDLE: begin
          if (hi_cnt == 3'h6) begin
            tms <= 1'b0;
            hi_cnt <= 3'h7;
          end else if (kind == 2'h2) begin
            tms <= 1'b0;
            hi_cnt <= 3'h7;
          end else begin
            // high once for dr, twice for ir
            tms <= 1'b1;
          end
        end
        TAP_SEL_DR: tms <= kind != 2'h1;
        TAP_SEL_IR: tms <= 1'b0;
        TAP_CAP_DR, TAP_CAP_IR: tms <= len == 9'h000;
        TAP_SH_DR, TAP_SH_IR: begin
          // stay low for the register length
          // last bit goes with a high, into exit1
          tms <= last_bit || (pause_req && !paused
            && bitn == {1'b0, len[8:1]});
          tdi <= (kind == 2'h0) ? ir[bitn[2:0]] : tdi_word[bitn[3:0]];
        end
        TAP_EX1_DR, TAP_EX1_IR: begin
          // one optional pause, otherwise on to update
          tms <= !(pause_req && !paused && bitn != len);
        end
        TAP_PAU_DR, TAP_PAU_IR: begin
          paused <= 1'b1;
          tms <= paused;
        end
        TAP_EX2_DR, TAP_EX2_IR: tms <= 1'b0;
        // update then back to idle with a low
        TAP_UPD_DR, TAP_UPD_IR: begin
          tms <= 1'b0;
          hi_cnt <= 3'h6;
        end
        default: tms <= 1'b1;
      endcase
    end
  end
  // data word for shift-dr; bits beyond 16 repeat this word
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdi_word <= '0;
    end else if (seq == SEQ_IDLE && cmd_valid_i) begin
      tdi_word <= cmd_tdi_i;
    end
  end
  // device output moves on the falling edge; three-stage sync
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tdo_sync <= 3'h0;
      tdo_bit <= 1'b0;
    end else begin
      tdo_sync <= {tdo_sync[1:0], test_data_out_pin_i};
      if (tdo_sync[2] == tdo_sync[1]) begin
        tdo_bit <= tdo_sync[2];
      end
    end
  end
  // bits sampled at rising edge in shift, cell 0 first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_sh <= '0;
      rx_n <= 5'h00;
      rx_push <= 1'b0;
      rx_word <= '0;
    end else begin
      if (rx_push && rx_ready) begin
        rx_push <= 1'b0;
      end
      if (rise && shifting && (!rx_push || rx_ready)) begin
        rx_sh <= {tdo_bit, rx_sh[FIFO_WIDTH-1:1]};
        rx_n <= rx_n + 5'h01;
        if (rx_n == 5'(FIFO_WIDTH-1) || last_bit) begin
          rx_word <= {tdo_bit, rx_sh[FIFO_WIDTH-1:1]}
            >> (5'(FIFO_WIDTH-1) - rx_n);
          rx_push <= 1'b1;
          rx_n <= 5'h00;
        end
      end
    end
  end
  bstap_fifo #(
    .WIDTH(FIFO_WIDTH),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_ready),
    .in_data_i(rx_word),
    .out_valid_o(rx_valid_o),
    .out_ready_i(rx_ready_i),
    .out_data_o(rx_data_o)
  );
endmodule : bstap_host

// ==== pkg/bstap_pkg.sv ====
// shared constants for the boundary-scan tester controller
package bstap_pkg;
  localparam int CLK_PERIOD_NS = 8;
  // half period of generated test clock, in ns
  localparam int TCK_HALF_NS = 40;
  localparam int TCK_HALF_CYC = (TCK_HALF_NS + CLK_PERIOD_NS - 1)
    / CLK_PERIOD_NS;
  localparam logic [3:0] TCK_HALF = 4'(TCK_HALF_CYC);
  localparam int IR_LEN = 6;
  localparam int BSR_LEN = 475;
  localparam int ID_LEN = 32;
  localparam int DR_MAX = 475;
  localparam int RESET_TMS_CYC = 5;
  localparam logic [5:0] IR_CAPTURE = 6'h31;
  localparam logic [5:0] IR_EXTEST = 6'h00;
  localparam logic [5:0] IR_SAMPLE = 6'h01;
  localparam logic [5:0] IR_IDCODE = 6'h02;
  localparam logic [5:0] IR_BYPASS = 6'h3F;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 16;
  // tap states, one-hot
  typedef enum logic [15:0] {
    TAP_RESET = 16'h0001, TAP_IDLE = 16'h0002, TAP_SEL_DR = 16'h0004,
    TAP_CAP_DR = 16'h0008, TAP_SH_DR = 16'h0010, TAP_EX1_DR = 16'h0020,
    TAP_PAU_DR = 16'h0040, TAP_EX2_DR = 16'h0080, TAP_UPD_DR = 16'h0100,
    TAP_SEL_IR = 16'h0200, TAP_CAP_IR = 16'h0400, TAP_SH_IR = 16'h0800,
    TAP_EX1_IR = 16'h1000, TAP_PAU_IR = 16'h2000, TAP_EX2_IR = 16'h4000,
    TAP_UPD_IR = 16'h8000
  } bstap_state_type;
  // sequencer states, one-hot
  typedef enum logic [4:0] {
    SEQ_IDLE = 5'h01, SEQ_LOAD = 5'h02, SEQ_HI = 5'h04, SEQ_LO = 5'h08,
    SEQ_DONE = 5'h10
  } bstap_seq_type;
endpackage : bstap_pkg

// ==== design/bstap_fifo.sv ====
// small valid/ready fifo
`timescale 1ns/1ps
module bstap_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  logic [AW:0] cnt;
  logic push;
  logic pop;
  assign in_ready_o = cnt != (AW+1)'(DEPTH);
  assign out_valid_o = cnt != '0;
  assign out_data_o = mem[rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wp] <= in_data_i;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      if (push) begin
        wp <= (wp == AW'(DEPTH-1)) ? '0 : wp + 1'b1;
      end
      if (pop) begin
        rp <= (rp == AW'(DEPTH-1)) ? '0 : rp + 1'b1;
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : bstap_fifo

// ==== dv/bstap_host_monitor.sv ====
// assertion checker for the tap sequencer pins and handshakes
`timescale 1ns/1ps
module bstap_host_monitor
  import bstap_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic rx_valid_o,
  input wire logic rx_ready_i,
  input wire logic [FIFO_WIDTH-1:0] rx_data_o,
  input wire logic busy_o,
  input wire logic test_clock_pin_o,
  input wire logic test_mode_select_pin_o,
  input wire logic test_data_in_pin_o,
  input wire logic test_reset_n_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence tck_high_s;
    test_clock_pin_o [*5] ##1 !test_clock_pin_o;
  endsequence
  sequence take_s;
    cmd_valid_i && cmd_ready_o;
  endsequence
  tck_half_a: assert property ($rose(test_clock_pin_o) |-> tck_high_s)
    else $error("test clock high phase wrong");
  pin_setup_a: assert property (test_clock_pin_o |->
    $stable(test_mode_select_pin_o) && $stable(test_data_in_pin_o))
    else $error("pins moved while test clock high");
  take_busy_a: assert property (take_s |=> busy_o && !cmd_ready_o)
    else $error("command taken but not running");
  ready_busy_a: assert property (!(cmd_ready_o && busy_o))
    else $error("ready while busy");
  idle_tck_a: assert property (!busy_o |-> !test_clock_pin_o)
    else $error("test clock not low when idle");
  idle_stay_a: assert property (cmd_ready_o && !cmd_valid_i |=>
    cmd_ready_o && !busy_o)
    else $error("left idle without command");
  reset_pins_a: assert property ($fell(rst_i) |->
    test_mode_select_pin_o && !test_clock_pin_o && !test_reset_n_pin_o &&
    !rx_valid_o)
    else $error("pin reset values wrong");
  trst_hold_a: assert property (!test_reset_n_pin_o && cmd_ready_o &&
    !cmd_valid_i |=> !test_reset_n_pin_o)
    else $error("test reset released early");
  trst_rise_a: assert property ($rose(test_reset_n_pin_o) |->
    test_mode_select_pin_o)
    else $error("test reset released with mode select low");
  rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=>
    rx_valid_o && $stable(rx_data_o))
    else $error("rx word dropped while stalled");
endmodule : bstap_host_monitor
bind bstap_host bstap_host_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i),
  .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i), .rx_data_o(rx_data_o),
  .busy_o(busy_o), .test_clock_pin_o(test_clock_pin_o),
  .test_mode_select_pin_o(test_mode_select_pin_o),
  .test_data_in_pin_o(test_data_in_pin_o),
  .test_reset_n_pin_o(test_reset_n_pin_o));

// ==== dv/bstap_dev_model.sv ====
// behavioural boundary-scan device on the far side of the pins
`timescale 1ns/1ps
module bstap_dev_model
  import bstap_pkg::*;
#(
  // arbitrary identification value
  parameter logic [31:0] ID_VALUE = 32'h1357_9BDF
) (
  input wire logic tck_i,
  input wire logic tms_i,
  input wire logic tdi_i,
  input wire logic trst_n_i,
  output logic tdo_o = 1'b0
);
  bstap_state_type st;
  logic [5:0] ir, ir_sh;
  logic [DR_MAX-1:0] sh, bsr = '0;
  int len, nsh;
  logic paused;
  assign len = (ir == IR_BYPASS) ? 1 : (ir == IR_IDCODE) ? ID_LEN : BSR_LEN;
  always @(posedge tck_i or negedge trst_n_i) begin
    if (!trst_n_i) begin
      st <= TAP_RESET;
      ir <= IR_IDCODE;
    end else begin
      case (st)
        TAP_RESET: st <= tms_i ? TAP_RESET : TAP_IDLE;
        TAP_IDLE: st <= tms_i ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR: st <= tms_i ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR, TAP_SH_DR: st <= tms_i ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR: st <= tms_i ? TAP_UPD_DR : TAP_PAU_DR;
        TAP_PAU_DR: st <= tms_i ? TAP_EX2_DR : TAP_PAU_DR;
        TAP_EX2_DR: st <= tms_i ? TAP_UPD_DR : TAP_SH_DR;
        TAP_SEL_IR: st <= tms_i ? TAP_RESET : TAP_CAP_IR;
        TAP_CAP_IR, TAP_SH_IR: st <= tms_i ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR: st <= tms_i ? TAP_UPD_IR : TAP_PAU_IR;
        TAP_PAU_IR: st <= tms_i ? TAP_EX2_IR : TAP_PAU_IR;
        TAP_EX2_IR: st <= tms_i ? TAP_UPD_IR : TAP_SH_IR;
        default: st <= tms_i ? TAP_SEL_DR : TAP_IDLE;
      endcase
      if (st == TAP_RESET) ir <= IR_IDCODE;
      if (st == TAP_CAP_IR) begin
        ir_sh <= IR_CAPTURE;
        nsh <= 0;
        paused <= 1'b0;
      end
      if (st == TAP_SH_IR) begin
        ir_sh <= {tdi_i, ir_sh[5:1]};
        nsh <= nsh + 1;
      end
      if (st == TAP_UPD_IR) ir <= ir_sh;
      // capture data, boundary sample loops back
      if (st == TAP_CAP_DR) begin
        nsh <= 0;
        paused <= 1'b0;
        sh <= (ir == IR_BYPASS) ? '0 :
          (ir == IR_IDCODE) ? DR_MAX'(ID_VALUE) : bsr;
      end
      if (st == TAP_SH_DR) begin
        sh <= sh >> 1;
        sh[len-1] <= tdi_i;
        nsh <= nsh + 1;
      end
      if (st == TAP_PAU_DR || st == TAP_PAU_IR) paused <= 1'b1;
      if (st == TAP_UPD_DR && (ir == IR_EXTEST || ir == IR_SAMPLE)) bsr <= sh;
    end
  end
  // falling edge, released line toggles so stale bits never match
  always @(negedge tck_i) begin
    tdo_o <= (st == TAP_SH_IR) ? ir_sh[0] : (st == TAP_SH_DR) ? sh[0] : ~tdo_o;
  end
endmodule : bstap_dev_model

// ==== dv/testbench.sv ====
// self-checking bench: tap sequencer against the device model
`timescale 1ns/1ps
module testbench import bstap_pkg::*;;
  localparam logic [15:0] PAT = 16'hA5C3;
  localparam logic [31:0] ID = 32'h1357_9BDF;
  logic clk_i = 0, rst_i = 1, cmd_valid = 0, cmd_pause = 0, rx_ready = 0;
  logic sink_en = 1, cmd_ready, rx_valid, busy, tck, tms, tdi, trst_n, tdo;
  logic [1:0] cmd_kind = 0;
  logic [8:0] cmd_len = 0;
  logic [5:0] cmd_ir = 0;
  logic [15:0] cmd_tdi = 0, rx_data;
  logic [15:0] q[$];
  int failures = 0, cmp_count = 0;
  always #4 clk_i = ~clk_i;
  bstap_host u_dut (.clk_i(clk_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid),
    .cmd_ready_o(cmd_ready), .cmd_kind_i(cmd_kind), .cmd_len_i(cmd_len),
    .cmd_ir_i(cmd_ir), .cmd_tdi_i(cmd_tdi), .cmd_pause_i(cmd_pause),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .rx_data_o(rx_data),
    .busy_o(busy), .test_clock_pin_o(tck), .test_mode_select_pin_o(tms),
    .test_data_in_pin_o(tdi), .test_reset_n_pin_o(trst_n),
    .test_data_out_pin_i(tdo));
  bstap_dev_model #(.ID_VALUE(ID)) u_dev (.tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .trst_n_i(trst_n), .tdo_o(tdo));
  always @(negedge clk_i) rx_ready <= sink_en;
  always @(posedge clk_i)
    if (rx_valid === 1'b1 && rx_ready) q.push_back(rx_data);
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic run(input logic [1:0] k, input logic [8:0] n,
    input logic [5:0] c, input logic [15:0] d, input logic p);
    int i;
    i = 0;
    @(negedge clk_i);
    {cmd_kind, cmd_len, cmd_ir, cmd_tdi, cmd_pause} = {k, n, c, d, p};
    cmd_valid = 1;
    @(posedge clk_i);
    while (cmd_ready !== 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    cmd_valid = 0;
    while (busy !== 1'b0 && i < 9000) begin
      @(negedge clk_i);
      i++;
    end
    chk("command done", 0, 32'(busy));
    // settle time for the last word through the fifo
    repeat (20) @(negedge clk_i);
  endtask : run
  task automatic t_reset;
    run(2, 0, 0, 0, 0);
    chk("tap state", 32'(TAP_IDLE), 32'(u_dev.st));
    chk("instruction", 32'(IR_IDCODE), 32'(u_dev.ir));
  endtask : t_reset
  task automatic t_ir(input logic [5:0] code);
    q.delete();
    run(0, 0, code, 0, 0);
    chk("ir words", 1, q.size());
    chk("ir capture", 32'h31, 32'(q[0]));
    chk("ir shifts", 6, u_dev.nsh);
    chk("instruction", 32'(code), 32'(u_dev.ir));
  endtask : t_ir
  task automatic t_ir_pause;
    q.delete();
    run(0, 0, IR_BYPASS, 0, 1);
    chk("ir paused", 1, 32'(u_dev.paused));
    chk("ir shifts", 6, u_dev.nsh);
    chk("ir capture", 32'h31, 32'(q[0]));
    chk("instruction", 32'(IR_BYPASS), 32'(u_dev.ir));
  endtask : t_ir_pause
  task automatic t_idcode;
    q.delete();
    run(1, 32, 0, 0, 0);
    chk("id words", 2, q.size());
    chk("id low", 32'(ID[15:0]), 32'(q[0]));
    chk("id high", 32'(ID[31:16]), 32'(q[1]));
  endtask : t_idcode
  task automatic t_bypass;
    t_ir(IR_BYPASS);
    q.delete();
    run(1, 1, 0, 16'hFFFF, 0);
    chk("bypass bit", 0, 32'(q[0]));
  endtask : t_bypass
  task automatic t_boundary;
    t_ir(IR_SAMPLE);
    run(1, 475, 0, PAT, 1);
    chk("paused", 1, 32'(u_dev.paused));
    chk("dr shifts", 475, u_dev.nsh);
    for (int n = 0; n < BSR_LEN; n++) begin
      chk("cell", 32'(PAT[n % 16]), 32'(u_dev.bsr[n]));
    end
    q.delete();
    run(1, 475, 0, PAT, 0);
    chk("bsr words", 30, q.size());
    for (int w = 0; w < 29; w++) chk("bsr word", 32'(PAT), 32'(q[w]));
    chk("bsr tail", 32'h05C3, 32'(q[29]));
  endtask : t_boundary
  task automatic t_stall;
    t_ir(IR_EXTEST);
    q.delete();
    sink_en = 0;
    run(1, 64, 0, 0, 0);
    chk("rx held", 1, 32'(rx_valid));
    sink_en = 1;
    repeat (20) @(negedge clk_i);
    chk("rx drained", 4, q.size());
    for (int w = 0; w < 4; w++) chk("extest word", 32'(PAT), 32'(q[w]));
  endtask : t_stall
  task automatic final_report;
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 0;
    t_reset();
    t_idcode();
    t_bypass();
    t_boundary();
    t_stall();
    t_ir_pause();
    t_ir(IR_IDCODE);
    t_idcode();
    final_report();
  end
  // run needs near 12500 cycles; the limit leaves wide margin
  initial begin
    #400000;
    failures++;
    final_report();
  end
endmodule : testbench
